//--- bench/hdf_host_model.sv
`timescale 1ns/1ps

// ==========
// Host memory channel model
module hdf_host_model (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Sync reset
  input  wire logic        slow,         // Grant every other cycle
  input  wire logic        req,          // Request from block
  input  wire logic [15:0] data,         // Half from block
  input  wire logic [15:0] addr,         // Host address
  output logic             grant,        // Grant level
  output logic [7:0]       taken,        // Halves taken
  output logic [15:0]      got_data [2], // Halves by parity
  output logic [15:0]      got_addr [2]  // Addresses by parity
);
  logic       tick;
  logic [7:0] kept;

  // Grant follows request, halved when slow
  always_ff @(posedge clk) begin
    tick  <= rst ? 1'b0 : ~tick;
    grant <= !rst && req && (!slow || tick);
  end

  // Record each half moved
  always_ff @(posedge clk) begin
    if (rst) begin
      taken <= 8'h00;
      kept  <= 8'h00;
    end else if (grant && req) begin
      got_data[taken[0]] <= data;
      got_addr[taken[0]] <= addr;
      taken <= taken + 8'h01;
      if (taken > 8'h01) kept <= kept + 8'h01;
    end
  end
endmodule // hdf_host_model

//--- bench/hdf_top_properties.sv
`timescale 1ns/1ps

// ==========
// Port-level checks of the host transfer block
module hdf_top_properties #(
  parameter int DATA_W = 32                          // Formatter word width
) (
  input wire logic                 clk,                // System clock
  input wire logic                 rst,                // Sync reset
  input wire hdf_pkg::hdf_io_req_t io_req,             // Processor strobes
  input wire logic [DATA_W-1:0]    io_input_bus,       // Processor out data
  input wire logic [DATA_W-1:0]    io_read_bus,        // Data to processor
  input wire logic                 formatter_ready,    // Ready answer
  input wire logic [15:0]          host_data_in,       // Host data
  input wire logic                 host_ctl_wr,        // Host control write
  input wire logic                 host_dma_grant,     // Host grant
  input wire logic                 host_dma_req,       // Block request
  input wire logic                 irq_priority_grant, // Priority grant
  input wire logic [3:0]           burst_switch,       // Burst length
  input wire logic                 internal_irq_flag,  // Internal flag
  input wire logic                 host_irq            // Host interrupt
);
  logic [15:0] sh;
  logic        go_seen, stb;
  logic [4:0]  run, lim;

  // Strobe and word limit per request run
  assign stb = io_req.in_strobe || io_req.out_strobe || io_req.sense_strobe;
  assign lim = !sh[7] ? 5'h01 : (burst_switch == 4'h0) ? 5'h10 : {1'b0, burst_switch};

  // Shadow of the last control word written
  always_ff @(posedge clk) begin
    if (rst) sh <= 16'h0000;
    else if (io_req.out_strobe && io_req.device_select == 8'h02) sh <= io_input_bus[15:0];
    else if (host_ctl_wr) sh <= host_data_in;
  end

  // Remembers that the processor ever wrote a start to device 2
  always_ff @(posedge clk) begin
    if (rst) go_seen <= 1'b0;
    else if (io_req.out_strobe && io_req.device_select == 8'h02 && io_input_bus[0]) go_seen <= 1'b1;
  end

  // Words moved since the request last rose
  always_ff @(posedge clk) begin
    if (rst || !host_dma_req) run <= 5'h00;
    else if (host_dma_grant) run <= run + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ready_cause; formatter_ready |-> $past(stb); endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without strobe");
  property p_unmapped;
    io_req.in_strobe && io_req.device_select > 8'h04 |=> !formatter_ready && io_read_bus == {DATA_W{1'b0}};
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read answered");
  property p_reg_ready; stb && io_req.device_select < 8'h04 |=> formatter_ready; endproperty
  a_reg_ready: assert property (p_reg_ready)
    else $error("register access not ready");
  property p_pace; host_dma_req && host_dma_grant |-> run < lim; endproperty
  a_pace: assert property (p_pace)
    else $error("request held too long");
  property p_irq_grant; internal_irq_flag |-> irq_priority_grant || $past(irq_priority_grant); endproperty
  a_irq_grant: assert property (p_irq_grant)
    else $error("flag without priority grant");
  property p_uncond; sh[14] && irq_priority_grant |=> ##[0:1] internal_irq_flag; endproperty
  a_uncond: assert property (p_uncond)
    else $error("unconditional flag missing");
  property p_host_irq; host_irq |-> $past(sh[12] || sh[11] || sh[10]); endproperty
  a_host_irq: assert property (p_host_irq)
    else $error("host irq without enable");
  property p_req_go; $rose(host_dma_req) |-> go_seen; endproperty
  a_req_go: assert property (p_req_go)
    else $error("request without start");

  c_word: cover property (host_dma_req && host_dma_grant);
  c_flag: cover property (internal_irq_flag);
  c_hirq: cover property (host_irq);
endmodule // hdf_top_properties

//--- bench/testbench.sv
`timescale 1ns/1ps

// ==========
// Bench top
module testbench;
  logic                 clk, rst, formatter_ready, host_ctl_wr, host_dma_grant, host_dma_req;
  logic                 proc_halted, irq_priority_grant, internal_irq_flag, host_irq, slow, rrdy;
  hdf_pkg::hdf_io_req_t io_req;
  logic [31:0]          io_input_bus, io_read_bus, rdat;
  logic [15:0]          host_data_in, host_data_out, host_addr;
  logic [15:0]          got_data [2];
  logic [15:0]          got_addr [2];
  logic [3:0]           burst_switch;
  logic [7:0]           taken;
  int                   num_errors = 0, cmp_count = 0, cyc = 0;

  hdf_top hdf_top_i (
    .clk(clk), .rst(rst), .io_req(io_req), .io_input_bus(io_input_bus),
    .io_read_bus(io_read_bus), .formatter_ready(formatter_ready),
    .host_data_in(host_data_in), .host_dma_grant(host_dma_grant), .host_pio_rd(1'b0),
    .host_pio_wr(1'b0), .host_ctl_wr(host_ctl_wr), .host_fn_wr(1'b0),
    .host_dma_req(host_dma_req), .host_data_out(host_data_out), .host_addr(host_addr),
    .main_store_rdata(32'h0000_0000), .main_store_addr(), .main_store_rd(),
    .main_store_wr(), .main_store_wdata(), .conv_fault(1'b0), .proc_halted(proc_halted),
    .irq_priority_grant(irq_priority_grant), .burst_switch(burst_switch),
    .internal_irq_flag(internal_irq_flag), .host_irq(host_irq));

  hdf_host_model hdf_host_model_i (
    .clk(clk), .rst(rst), .slow(slow), .req(host_dma_req), .data(host_data_out),
    .addr(host_addr), .grant(host_dma_grant), .taken(taken), .got_data(got_data),
    .got_addr(got_addr));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // One processor cycle, kind 1 is an output
  task automatic io(input logic kind, input logic [7:0] sel, input logic [31:0] d);
    @(posedge clk);
    #1;
    io_req.in_strobe = !kind;
    io_req.out_strobe = kind;
    io_req.device_select = sel;
    io_input_bus = d;
    @(posedge clk);
    #1;
    io_req.in_strobe = 1'b0;
    io_req.out_strobe = 1'b0;
    rdat = io_read_bus;
    rrdy = formatter_ready;
  endtask

  // ==========
  // Scenarios
  task automatic t_regs;
    logic [15:0] v [4];
    v = '{16'h1234, 16'h5678, 16'h0000, 16'h9abc};
    for (int i = 0; i < 4; i++) begin
      if (i != 2) begin
        io(0, 8'(i), 32'h0000_0000);
        chk(32'(rdat[15:0]), 32'h0000_0000);
        io(1, 8'(i), 32'(v[i]));
        io(0, 8'(i), 32'h0000_0000);
        chk(32'(rdat[15:0]), 32'(v[i]));
      end
    end
    io(0, 8'h05, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(32'(rrdy), 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_dma(input logic [15:0] cw, input logic sl);
    logic [7:0]  base;
    slow = sl;
    base = taken;
    io(1, 8'h00, 32'h0000_0002);
    io(1, 8'h01, 32'h0000_0100);
    io(1, 8'h02, 32'(cw));
    io(1, 8'h04, 32'hcafe_f00d);
    chk(32'(rrdy), 32'h0000_0001);
    for (int i = 0; i < 40 && taken != base + 8'h02; i++) @(posedge clk);
    wt();
    chk(32'(got_data[0]), cw[3] ? 32'h0000_f00d : 32'h0000_cafe);
    chk(32'(got_data[1]), cw[3] ? 32'h0000_cafe : 32'h0000_f00d);
    chk(32'(got_addr[0]), 32'h0000_0100);
    chk(32'(got_addr[1]), cw[3] ? 32'h0000_00ff : 32'h0000_0101);
    io(0, 8'h00, 32'h0000_0000);
    chk(32'(rdat[15:0]), 32'h0000_0000);
    io(0, 8'h02, 32'h0000_0000);
    chk(32'({rdat[15], rdat[0]}), 32'h0000_0002);
    $display("test dma %h done", cw);
  endtask
  task automatic t_irq;
    irq_priority_grant = 1'b0;
    host_data_in = 16'h4000;
    host_ctl_wr = 1'b1;
    @(posedge clk);
    #1;
    host_ctl_wr = 1'b0;
    wt();
    chk(32'(internal_irq_flag), 32'h0000_0000);
    irq_priority_grant = 1'b1;
    wt();
    chk(32'(internal_irq_flag), 32'h0000_0001);
    io(1, 8'h02, 32'h0000_2000);
    wt();
    chk(32'(internal_irq_flag), 32'h0000_0001);
    proc_halted = 1'b1;
    io(1, 8'h02, 32'h0000_0000);
    wt();
    chk(32'(internal_irq_flag), 32'h0000_0000);
    chk(32'(host_irq), 32'h0000_0000);
    io(1, 8'h02, 32'h0000_1000);
    wt();
    chk(32'(host_irq), 32'h0000_0001);
    $display("test irq done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    io_req = 11'h000;
    io_input_bus = 32'h0000_0000;
    host_data_in = 16'h0000;
    host_ctl_wr = 1'b0;
    proc_halted = 1'b0;
    irq_priority_grant = 1'b0;
    burst_switch = 4'h2;
    slow = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_dma(16'h0021, 1'b0);
    t_dma(16'h0029, 1'b1);
    t_dma(16'h00a1, 1'b0);
    t_irq();
    wrap_up();
  end
endmodule // testbench

bind hdf_top hdf_top_properties #(.DATA_W(DATA_W)) hdf_top_properties_i (
  .clk(clk), .rst(rst), .io_req(io_req), .io_input_bus(io_input_bus),
  .io_read_bus(io_read_bus), .formatter_ready(formatter_ready), .host_data_in(host_data_in),
  .host_ctl_wr(host_ctl_wr), .host_dma_grant(host_dma_grant), .host_dma_req(host_dma_req),
  .irq_priority_grant(irq_priority_grant), .burst_switch(burst_switch),
  .internal_irq_flag(internal_irq_flag), .host_irq(host_irq));

//--- core/hdf_params.svh
`ifndef HDF_PARAMS_SVH
`define HDF_PARAMS_SVH

// ==========================================================
// Device addresses on the processor I/O bus
`define HDF_DEV_COUNT      8'h00
`define HDF_DEV_HOST_PTR   8'h01
`define HDF_DEV_CTL        8'h02
`define HDF_DEV_LOCAL_PTR  8'h03
`define HDF_DEV_FORMATTER  8'h04

// ==========================================================
// Control word reset value and writable mode field (bits 1..7)
`define HDF_CTL_RESET      16'h0000
`define HDF_MODE_MSB       7
`define HDF_MODE_LSB       1

// ==========================================================
// Format selector codes
`define HDF_FMT_INT32      2'h0
`define HDF_FMT_INT16      2'h1
`define HDF_FMT_BINEXP     2'h2
`define HDF_FMT_HEXEXP     2'h3

// ==========================================================
// Register reset values and burst switch meaning
`define HDF_COUNT_RESET    16'h0000
`define HDF_PTR_RESET      16'h0000
`define HDF_BURST_FULL     4'hf

`endif

//--- core/hdf_pkg.sv
// ==========================================================
// Shared types
package hdf_pkg;

  // Control word, bit 15 first (documented bit 0 sits at bit 15)
  typedef struct packed {
    logic       count_zero;
    logic       unconditional_irq_enable;
    logic       transfer_done_irq_enable;
    logic       halted_host_irq_enable;
    logic       done_host_irq_enable;
    logic       signalled_host_irq_enable;
    logic       conversion_range_error;
    logic       data_late;
    logic       burst_transfer;
    logic       local_memory_transfer_enable;
    logic       to_host_direction;
    logic       local_address_down;
    logic       host_address_down;
    logic [1:0] format_sel;
    logic       host_transfer_go;
  } hdf_ctl_t;

  // Processor I/O instruction strobes plus device select
  typedef struct packed {
    logic       in_strobe;
    logic       out_strobe;
    logic       sense_strobe;
    logic [7:0] device_select;
  } hdf_io_req_t;

  // Request pacer states
  typedef enum logic [1:0] {
    PACE_IDLE,
    PACE_ON,
    PACE_GAP
  } hdf_pace_state_t;

endpackage

//--- core/hdf_req_pacer.sv
`timescale 1ns/1ps
`include "hdf_params.svh"

// ==========================================================
// Host DMA request pacing
module hdf_req_pacer (
  input  wire logic       clk,          // System clock
  input  wire logic       rst,          // Sync reset, active high
  input  wire logic       go,           // Transfer active (next state)
  input  wire logic       ok,           // Formatter can serve the host
  input  wire logic       burst,        // Burst mode selected
  input  wire logic [3:0] burst_len,    // Burst switch, 0 means 16
  input  wire logic       grant,        // Host grant
  output logic            req           // DMA request to host
);

  hdf_pkg::hdf_pace_state_t state_reg;
  logic [3:0]               cnt_reg;
  logic [3:0]               limit;
  logic                     can_go;

  // Last word index of a burst
  assign limit  = (burst_len == 4'h0) ? `HDF_BURST_FULL : burst_len - 4'h1;
  assign can_go = go & ok;

  // Request state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= hdf_pkg::PACE_IDLE;
      req       <= 1'b0;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        hdf_pkg::PACE_IDLE: begin
          if (can_go) begin
            state_reg <= hdf_pkg::PACE_ON;
            req       <= 1'b1;
            cnt_reg   <= 4'h0;
          end
        end
        hdf_pkg::PACE_ON: begin
          if (grant && (!burst || cnt_reg == limit)) begin
            state_reg <= hdf_pkg::PACE_GAP;
            req       <= 1'b0;
            cnt_reg   <= 4'h0;
          end else if (!can_go) begin
            state_reg <= hdf_pkg::PACE_IDLE;
            req       <= 1'b0;
          end else if (grant) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        hdf_pkg::PACE_GAP: begin
          state_reg <= can_go ? hdf_pkg::PACE_ON : hdf_pkg::PACE_IDLE;
          req       <= can_go;
        end
        default: begin
          state_reg <= hdf_pkg::PACE_IDLE;
          req       <= 1'b0;
        end
      endcase
    end
  end

endmodule // hdf_req_pacer

//--- core/hdf_top.sv
`timescale 1ns/1ps
`include "hdf_params.svh"

// What this block does
// - Input bus chosen by direction and local-enable bits
// - Direction bit sets processor-to-host or host-to-processor
// - Host-down bit takes low half first
// - Formatter answers device 4 instructions with ready
// - Ready means accept when to-host, deliver otherwise
// - Standard and four mixed DMA modes
// - Count register at address 0 holds length
// - Host pointer register at address 1
// - Local pointer register at address 3
// - Go bit raises host request, grant moves word
// - Non-burst drops request one cycle per word
// - Burst drops request after switch-set word count
// - Transfer runs until count zero, a mode-changing control write, or reset
// - Range error flag set on conversion fault in to-host exponent formats
// - Unconditional enable sets internal irq flag
// - Done enable with go clear sets flag
// - Internal flag is level, testable by branch
// - Internal irq also needs priority grant
// - Host irqs need enable and condition
// - Writing go zero while active is harmless
// - Down bits decrement pointers, else increment
module hdf_top #(
  parameter int DATA_W = 32                  // Formatter word width
) (
  input  wire logic                clk,                 // System clock
  input  wire logic                rst,                 // Sync reset, active high
  input  wire hdf_pkg::hdf_io_req_t io_req,             // Processor I/O strobes
  input  wire logic [DATA_W-1:0]   io_input_bus,        // Processor output data
  output logic      [DATA_W-1:0]   io_read_bus,         // Data to processor
  output logic                     formatter_ready,     // Ready answer
  input  wire logic [15:0]         host_data_in,        // Host data bus in
  input  wire logic                host_dma_grant,      // Host DMA grant
  input  wire logic                host_pio_rd,         // Host programmed read
  input  wire logic                host_pio_wr,         // Host programmed write
  input  wire logic                host_ctl_wr,         // Host writes control word
  input  wire logic                host_fn_wr,          // Host clears signalled irq
  output logic                     host_dma_req,        // DMA request to host
  output logic      [15:0]         host_data_out,       // Host data bus out
  output logic      [15:0]         host_addr,           // Host memory address
  input  wire logic [DATA_W-1:0]   main_store_rdata,    // Main store read data
  output logic      [15:0]         main_store_addr,     // Main store address
  output logic                     main_store_rd,       // Main store read strobe
  output logic                     main_store_wr,       // Main store write strobe
  output logic      [DATA_W-1:0]   main_store_wdata,    // Main store write data
  input  wire logic                conv_fault,          // Exponent over/underflow
  input  wire logic                proc_halted,         // Processor halted
  input  wire logic                irq_priority_grant,  // Priority chain grant
  input  wire logic [3:0]          burst_switch,        // Burst length switch
  output logic                     internal_irq_flag,   // Level for branch test
  output logic                     host_irq             // Interrupt to host
);

  // ==========================================================
  // State
  hdf_pkg::hdf_ctl_t  ctl_reg;
  logic [15:0]        count_reg, hptr_reg, lptr_reg;
  logic [DATA_W-1:0]  fmt_word_reg;
  logic               fmt_full_reg, half_reg, ms_wait_reg, signal_pend_reg;

  // ==========================================================
  // Decode
  hdf_pkg::hdf_ctl_t  wr_ctl, ctl_next;
  logic               proc_ctl_wr, any_ctl_wr, to_host, local_en, single_half, dma_xfer;
  logic               host_take, host_put, last_half, proc_load, proc_unload, go_start;
  logic               ms_read_start, ms_write_start, go_end, fmt_full_next, half_next;
  logic [DATA_W-1:0]  fmt_word_next;
  logic [15:0]        half_out, hptr_step, lptr_step;

  // Which half the formatter handles; int16 moves one half per word
  assign to_host     = ctl_reg.to_host_direction;
  assign local_en    = ctl_reg.local_memory_transfer_enable;
  assign single_half = ctl_reg.format_sel == `HDF_FMT_INT16;
  assign last_half   = single_half | half_reg;

  // Host side moves: DMA cycles or host programmed I/O
  assign dma_xfer  = host_dma_grant & host_dma_req;
  assign host_take = to_host & ((dma_xfer & fmt_full_reg) | (host_pio_rd & fmt_full_reg));
  assign host_put  = !to_host & ((dma_xfer & !fmt_full_reg) | (host_pio_wr & !fmt_full_reg));

  // Processor side moves through device 4 unless main store is used
  assign proc_load   = io_req.out_strobe & (io_req.device_select == `HDF_DEV_FORMATTER)
                       & to_host & !fmt_full_reg & !local_en;
  assign proc_unload = io_req.in_strobe & (io_req.device_select == `HDF_DEV_FORMATTER)
                       & !to_host & fmt_full_reg & !local_en;
  assign ms_read_start  = local_en & to_host & !fmt_full_reg & !main_store_rd & !ms_wait_reg;
  assign ms_write_start = local_en & !to_host & fmt_full_reg & !main_store_wr;

  // Pointer steps
  assign hptr_step = ctl_reg.host_address_down ? hptr_reg - 16'h1 : hptr_reg + 16'h1;
  assign lptr_step = ctl_reg.local_address_down ? lptr_reg - 16'h1 : lptr_reg + 16'h1;

  // Control word writes
  assign proc_ctl_wr = io_req.out_strobe & (io_req.device_select == `HDF_DEV_CTL);
  assign any_ctl_wr  = proc_ctl_wr | host_ctl_wr;
  assign wr_ctl      = proc_ctl_wr ? hdf_pkg::hdf_ctl_t'(io_input_bus[15:0])
                                   : hdf_pkg::hdf_ctl_t'(host_data_in);
  assign go_start    = any_ctl_wr & !ctl_reg.host_transfer_go & wr_ctl.host_transfer_go
                       & (count_reg != 16'h0);
  assign go_end      = dma_xfer & (count_reg == 16'h1);

  // ==========================================================
  // Next control word
  always_comb begin
    ctl_next = ctl_reg;
    if (any_ctl_wr) begin
      ctl_next = wr_ctl;
      ctl_next.count_zero             = 1'b0;
      ctl_next.conversion_range_error = ctl_reg.conversion_range_error;
      ctl_next.data_late              = ctl_reg.data_late;
      if (proc_ctl_wr) begin
        ctl_next.signalled_host_irq_enable = ctl_reg.signalled_host_irq_enable;
      end
      if (ctl_reg.host_transfer_go) begin
        // Active: zero write leaves go set; changed mode ends it
        ctl_next.host_transfer_go =
          (wr_ctl[`HDF_MODE_MSB:`HDF_MODE_LSB] == ctl_reg[`HDF_MODE_MSB:`HDF_MODE_LSB]);
      end else begin
        ctl_next.host_transfer_go = go_start;
      end
      if (go_start) begin
        ctl_next.conversion_range_error = 1'b0;
        ctl_next.data_late              = 1'b0;
      end
    end
    if (go_end) begin
      ctl_next.host_transfer_go = 1'b0;
    end
    // Event set wins over the clear at start
    if (conv_fault && ctl_next.to_host_direction && ctl_next.format_sel[1]) begin
      ctl_next.conversion_range_error = 1'b1;
    end
    if ((host_pio_rd && to_host && !fmt_full_reg) || (host_pio_wr && !to_host && fmt_full_reg)) begin
      ctl_next.data_late = 1'b1;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_reg <= hdf_pkg::hdf_ctl_t'(`HDF_CTL_RESET);
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ==========================================================
  // Formatter word assembly
  always_comb begin
    fmt_word_next = fmt_word_reg;
    fmt_full_next = fmt_full_reg;
    half_next     = half_reg;
    if (proc_load) begin
      fmt_word_next = io_input_bus;
      fmt_full_next = 1'b1;
      half_next     = 1'b0;
    end else if (ms_wait_reg) begin
      fmt_word_next = main_store_rdata;
      fmt_full_next = 1'b1;
      half_next     = 1'b0;
    end else if (host_take) begin
      half_next     = !last_half;
      fmt_full_next = !last_half;
    end else if (host_put) begin
      // Host data bus is the source when direction is toward the processor
      if (single_half) begin
        fmt_word_next = {{(DATA_W-16){1'b0}}, host_data_in};
      end else if (ctl_reg.host_address_down ^ half_reg) begin
        fmt_word_next[15:0] = host_data_in;
      end else begin
        fmt_word_next[DATA_W-1:DATA_W-16] = host_data_in;
      end
      half_next     = !last_half;
      fmt_full_next = last_half;
    end else if (proc_unload || ms_write_start) begin
      fmt_full_next = 1'b0;
      half_next     = 1'b0;
    end
  end

  // Half presented to the host: low first when host address goes down
  always_comb begin
    if (single_half || (ctl_reg.host_address_down ^ half_next)) begin
      half_out = fmt_word_next[15:0];
    end else begin
      half_out = fmt_word_next[DATA_W-1:DATA_W-16];
    end
  end

  // Formatter registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fmt_word_reg  <= '0;
      fmt_full_reg  <= 1'b0;
      half_reg      <= 1'b0;
      host_data_out <= 16'h0;
    end else begin
      fmt_word_reg  <= fmt_word_next;
      fmt_full_reg  <= fmt_full_next;
      half_reg      <= half_next;
      host_data_out <= half_out;
    end
  end

  // ==========================================================
  // Main store cycles per formatter word
  always_ff @(posedge clk) begin
    if (rst) begin
      main_store_rd    <= 1'b0;
      main_store_wr    <= 1'b0;
      ms_wait_reg      <= 1'b0;
      main_store_addr  <= `HDF_PTR_RESET;
      main_store_wdata <= '0;
    end else begin
      main_store_rd <= ms_read_start;
      main_store_wr <= ms_write_start;
      ms_wait_reg   <= main_store_rd;
      if (ms_read_start || ms_write_start) begin
        main_store_addr <= lptr_reg;
      end
      if (ms_write_start) begin
        main_store_wdata <= fmt_word_reg;
      end
    end
  end

  // ==========================================================
  // Count and pointer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= `HDF_COUNT_RESET;
      hptr_reg  <= `HDF_PTR_RESET;
      lptr_reg  <= `HDF_PTR_RESET;
      host_addr <= `HDF_PTR_RESET;
    end else begin
      if (io_req.out_strobe && io_req.device_select == `HDF_DEV_COUNT) begin
        count_reg <= io_input_bus[15:0];
      end else if (dma_xfer) begin
        count_reg <= count_reg - 16'h1;
      end
      if (io_req.out_strobe && io_req.device_select == `HDF_DEV_HOST_PTR) begin
        hptr_reg  <= io_input_bus[15:0];
        host_addr <= io_input_bus[15:0];
      end else if (dma_xfer) begin
        hptr_reg  <= hptr_step;
        host_addr <= hptr_step;
      end
      if (io_req.out_strobe && io_req.device_select == `HDF_DEV_LOCAL_PTR) begin
        lptr_reg <= io_input_bus[15:0];
      end else if (ms_read_start || ms_write_start) begin
        lptr_reg <= lptr_step;
      end
    end
  end

  // ==========================================================
  // Processor reads and ready answers
  always_ff @(posedge clk) begin
    if (rst) begin
      io_read_bus     <= '0;
      formatter_ready <= 1'b0;
    end else begin
      formatter_ready <= 1'b0;
      if (io_req.in_strobe || io_req.out_strobe || io_req.sense_strobe) begin
        case (io_req.device_select)
          `HDF_DEV_COUNT, `HDF_DEV_HOST_PTR, `HDF_DEV_CTL, `HDF_DEV_LOCAL_PTR: begin
            formatter_ready <= 1'b1;
          end
          `HDF_DEV_FORMATTER: begin
            formatter_ready <= local_en ? 1'b0 : (to_host ? !fmt_full_reg : fmt_full_reg);
          end
          default: begin
            formatter_ready <= 1'b0;
          end
        endcase
      end
      if (io_req.in_strobe) begin
        case (io_req.device_select)
          `HDF_DEV_COUNT:     io_read_bus <= DATA_W'(count_reg);
          `HDF_DEV_HOST_PTR:  io_read_bus <= DATA_W'(hptr_reg);
          `HDF_DEV_CTL: begin
            io_read_bus <= DATA_W'({count_reg == 16'h0, ctl_reg[14:0]});
          end
          `HDF_DEV_LOCAL_PTR: io_read_bus <= DATA_W'(lptr_reg);
          `HDF_DEV_FORMATTER: io_read_bus <= proc_unload ? fmt_word_reg : io_read_bus;
          default:            io_read_bus <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Signalled host interrupt condition
  always_ff @(posedge clk) begin
    if (rst) begin
      signal_pend_reg <= 1'b0;
    end else if (proc_ctl_wr && wr_ctl.signalled_host_irq_enable) begin
      signal_pend_reg <= 1'b1;
    end else if (host_fn_wr || proc_ctl_wr) begin
      signal_pend_reg <= 1'b0;
    end
  end

  // Interrupt levels
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_irq_flag <= 1'b0;
      host_irq          <= 1'b0;
    end else begin
      internal_irq_flag <= irq_priority_grant
        & (ctl_reg.unconditional_irq_enable
        | (ctl_reg.transfer_done_irq_enable & !ctl_reg.host_transfer_go));
      host_irq <= (ctl_reg.halted_host_irq_enable & proc_halted)
        | (ctl_reg.done_host_irq_enable & !ctl_reg.host_transfer_go)
        | (ctl_reg.signalled_host_irq_enable & signal_pend_reg);
    end
  end

  // ==========================================================
  // Host request pacing
  hdf_req_pacer u_pacer (
    .clk       (clk),
    .rst       (rst),
    .go        (ctl_next.host_transfer_go),
    .ok        (to_host ? fmt_full_next : !fmt_full_next),
    .burst     (ctl_reg.burst_transfer),
    .burst_len (burst_switch),
    .grant     (host_dma_grant),
    .req       (host_dma_req)
  );

endmodule // hdf_top
